// *** wtc_pkg.sv ***
// Purpose: Shared constants for the wait timer and threshold compare block
// Assumes: Register addresses are the byte offsets seen by the serial front end
// Notes: Timing counts derive from the 40 ns system clock period
package wtc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_WAIT_DURATION = 8'h83;
	localparam logic [7:0] ADDR_LIGHT_LOW_LO = 8'h84;
	localparam logic [7:0] ADDR_LIGHT_LOW_HI = 8'h85;
	localparam logic [7:0] ADDR_LIGHT_HIGH_LO = 8'h86;
	localparam logic [7:0] ADDR_LIGHT_HIGH_HI = 8'h87;
	localparam logic [7:0] ADDR_NEAR_LOW_LO = 8'h88;
	localparam logic [7:0] ADDR_NEAR_LOW_HI = 8'h89;
	localparam logic [7:0] ADDR_NEAR_HIGH_LO = 8'h8a;
	localparam logic [7:0] ADDR_NEAR_HIGH_HI = 8'h8b;
	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	// Field layout of the upper proximity threshold byte and the short-mode result bits
	localparam int NEAR_HI_MSB = 5;
	localparam int NEAR_WIDTH = 14;
	localparam int NEAR_SHORT_MSB = 9;
	localparam int NEAR_SHORT_LSB = 2;
	// Wait timing: one increment in ns and its clock count
	localparam int CLK_PERIOD_NS = 40;
	localparam int WAIT_STEP_NS = 2780000;
	localparam int WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
	localparam logic [3:0] LONG_WAIT_FACTOR = 4'hc;
	// Light persistence table: codes above 3 mean 5 x (code - 3) results
	localparam logic [3:0] LIGHT_PERS_LINEAR_MAX = 4'h3;
	localparam logic [2:0] LIGHT_PERS_STEP = 3'h5;
	localparam int PERS_CNT_W = 6;
endpackage

// *** wtc_persist.sv ***
// Purpose: Persistence filter counting consecutive out-of-range results
// Assumes: eval is a one-cycle pulse per finished conversion
// Notes: A target of zero fires on every evaluated result
`timescale 1ns/1ns
module wtc_persist #(
	parameter int CW = 6
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Result qualification
	input wire logic eval,
	input wire logic out_of_range,
	input wire logic [CW-1:0] target,
	// Event out
	output logic hit
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic at_max;

	// Count saturates so a long run never wraps back onto the target
	assign at_max = &cnt_q;
	assign cnt_d = !out_of_range ? '0 : (at_max ? cnt_q : cnt_q + {{(CW-1){1'b0}}, 1'b1});
	assign hit = eval && ((target == '0) || (out_of_range && cnt_d == target));

	// Counter only moves on a finished conversion
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (eval) begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// *** wtc_top.sv ***
// Purpose: Wait timer, light and proximity thresholds, persistence and interrupt pin
// Assumes: The serial front end delivers decoded byte writes and reads
// Notes: Light and proximity results arrive with a one-cycle done pulse
//
// Functional notes
// R01: Wait lasts register value plus one increments of 2.78 ms.
// R02: Wait is timed by a down counter loaded from the wait register.
// R03: Long-wait select stretches every increment twelve times.
// R04: Light low limit bytes form 16 bits; clear result compared as falling limit.
// R05: Clear result below low limit with persistence met sets light flag.
// R06: Light high limit bytes form 16 bits; result above it sets light flag.
// R07: Interrupt pin asserts while light flag and its enable are both set.
// R08: Low byte waits in a shadow; upper byte write latches both together.
// R09: Host writes low byte first, then the high byte right after.
// R10: With pulse control on, proximity low limit is 14 bits from two registers.
// R11: Proximity result below low limit with persistence met sets proximity flag.
// R12: Interrupt pin asserts while proximity flag and its enable are both set.
// R13: Pulse control off gives a 10-bit result; upper limit bytes ignored.
// R14: Pulse control off compares 8-bit low-byte limits to result bits 9:2.
// R15: High limit low byte is the low half of the 14-bit high limit.
// R16: Host writes proximity low byte, then the upper-bits register right after.
// R17: Host keeps bits 7:6 of the upper-bits register at zero.
// R18: Proximity result above 14-bit high limit with persistence sets proximity flag.
// R19: Light persistence counts consecutive outside results, clears when inside.
// R20: Proximity persistence counts consecutive outside results, clears when inside.
// R21: Compares and counters advance once per finished conversion only.
// R22: All limit, shadow and wait registers reset to zero.
`timescale 1ns/1ns
module wtc_top #(
	parameter int STEP_CYCLES = wtc_pkg::WAIT_STEP_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register access from the serial front end
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Configuration bits held elsewhere
	input wire logic long_wait_select,
	input wire logic pulse_control_off,
	input wire logic [3:0] light_persistence,
	input wire logic [3:0] near_persistence,
	input wire logic light_interrupt_enable,
	input wire logic near_interrupt_enable,
	// Wait sequencing
	input wire logic wait_start,
	output logic wait_busy,
	output logic wait_done,
	// Conversion results
	input wire logic light_done,
	input wire logic [15:0] clear_result,
	input wire logic near_done,
	input wire logic [13:0] near_result,
	// Flag clears from the interrupt clear logic
	input wire logic light_flag_clear,
	input wire logic near_flag_clear,
	// Flags and interrupt pin
	output logic light_interrupt_flag,
	output logic near_interrupt_flag,
	output logic int_n
);
	localparam int SW = $clog2(STEP_CYCLES + 1);
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);
	localparam int CW = wtc_pkg::PERS_CNT_W;

	// Raw register bytes as written
	logic [7:0] wait_duration_q;
	logic [7:0] light_low_limit_lo_q;
	logic [7:0] light_low_limit_hi_q;
	logic [7:0] light_high_limit_lo_q;
	logic [7:0] light_high_limit_hi_q;
	logic [7:0] near_low_limit_lo_q;
	logic [7:0] near_low_limit_hi_q;
	logic [7:0] near_high_limit_lo_q;
	logic [7:0] near_high_limit_hi_q;
	// Effective limits, updated only on the upper byte write
	logic [15:0] light_low_eff_q;
	logic [15:0] light_high_eff_q;
	logic [13:0] near_low_eff_q;
	logic [13:0] near_high_eff_q;
	// Wait timer state
	logic [SW-1:0] step_q;
	logic [3:0] sub_q;
	logic [7:0] inc_q;
	logic wait_busy_q;
	logic wait_done_q;
	// Flags and pin
	logic light_flag_q;
	logic near_flag_q;
	logic int_n_q;
	logic [7:0] rdata_q;

	// Write decode
	logic wr_wait;
	logic wr_llo;
	logic wr_lhi;
	logic wr_hlo;
	logic wr_hhi;
	logic wr_nllo;
	logic wr_nlhi;
	logic wr_nhlo;
	logic wr_nhhi;
	assign wr_wait = reg_wr && reg_addr == wtc_pkg::ADDR_WAIT_DURATION;
	assign wr_llo = reg_wr && reg_addr == wtc_pkg::ADDR_LIGHT_LOW_LO;
	assign wr_lhi = reg_wr && reg_addr == wtc_pkg::ADDR_LIGHT_LOW_HI;
	assign wr_hlo = reg_wr && reg_addr == wtc_pkg::ADDR_LIGHT_HIGH_LO;
	assign wr_hhi = reg_wr && reg_addr == wtc_pkg::ADDR_LIGHT_HIGH_HI;
	assign wr_nllo = reg_wr && reg_addr == wtc_pkg::ADDR_NEAR_LOW_LO;
	assign wr_nlhi = reg_wr && reg_addr == wtc_pkg::ADDR_NEAR_LOW_HI;
	assign wr_nhlo = reg_wr && reg_addr == wtc_pkg::ADDR_NEAR_HIGH_LO;
	assign wr_nhhi = reg_wr && reg_addr == wtc_pkg::ADDR_NEAR_HIGH_HI;

	// Read select; unmapped offsets read as zero
	logic [7:0] rd_sel;
	always_comb begin
		if (reg_addr == wtc_pkg::ADDR_WAIT_DURATION) begin
			rd_sel = wait_duration_q;
		end else if (reg_addr == wtc_pkg::ADDR_LIGHT_LOW_LO) begin
			rd_sel = light_low_limit_lo_q;
		end else if (reg_addr == wtc_pkg::ADDR_LIGHT_LOW_HI) begin
			rd_sel = light_low_limit_hi_q;
		end else if (reg_addr == wtc_pkg::ADDR_LIGHT_HIGH_LO) begin
			rd_sel = light_high_limit_lo_q;
		end else if (reg_addr == wtc_pkg::ADDR_LIGHT_HIGH_HI) begin
			rd_sel = light_high_limit_hi_q;
		end else if (reg_addr == wtc_pkg::ADDR_NEAR_LOW_LO) begin
			rd_sel = near_low_limit_lo_q;
		end else if (reg_addr == wtc_pkg::ADDR_NEAR_LOW_HI) begin
			rd_sel = near_low_limit_hi_q;
		end else if (reg_addr == wtc_pkg::ADDR_NEAR_HIGH_LO) begin
			rd_sel = near_high_limit_lo_q;
		end else if (reg_addr == wtc_pkg::ADDR_NEAR_HIGH_HI) begin
			rd_sel = near_high_limit_hi_q;
		end else begin
			rd_sel = 8'h00;
		end
	end

	// Raw byte storage; the low bytes double as the shadow buffers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_duration_q <= wtc_pkg::REG_RESET; // R22
			light_low_limit_lo_q <= wtc_pkg::REG_RESET;
			light_low_limit_hi_q <= wtc_pkg::REG_RESET;
			light_high_limit_lo_q <= wtc_pkg::REG_RESET;
			light_high_limit_hi_q <= wtc_pkg::REG_RESET;
			near_low_limit_lo_q <= wtc_pkg::REG_RESET;
			near_low_limit_hi_q <= wtc_pkg::REG_RESET;
			near_high_limit_lo_q <= wtc_pkg::REG_RESET;
			near_high_limit_hi_q <= wtc_pkg::REG_RESET;
		end else begin
			if (wr_wait) wait_duration_q <= reg_wdata;
			if (wr_llo) light_low_limit_lo_q <= reg_wdata; // R08
			if (wr_lhi) light_low_limit_hi_q <= reg_wdata;
			if (wr_hlo) light_high_limit_lo_q <= reg_wdata; // R08
			if (wr_hhi) light_high_limit_hi_q <= reg_wdata;
			if (wr_nllo) near_low_limit_lo_q <= reg_wdata; // R08
			if (wr_nlhi) near_low_limit_hi_q <= reg_wdata;
			if (wr_nhlo) near_high_limit_lo_q <= reg_wdata; // R08
			if (wr_nhhi) near_high_limit_hi_q <= reg_wdata;
		end
	end

	// Atomic latch of each limit pair on its upper byte write
	// A lone low byte write disturbs only the short-mode proximity compare
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			light_low_eff_q <= wtc_pkg::LIMIT_RESET; // R22
			light_high_eff_q <= wtc_pkg::LIMIT_RESET;
			near_low_eff_q <= '0;
			near_high_eff_q <= '0;
		end else begin
			if (wr_lhi) light_low_eff_q <= {reg_wdata, light_low_limit_lo_q}; // R04 R08
			if (wr_hhi) light_high_eff_q <= {reg_wdata, light_high_limit_lo_q}; // R06 R08
			if (wr_nlhi) near_low_eff_q <= {reg_wdata[wtc_pkg::NEAR_HI_MSB:0], near_low_limit_lo_q}; // R10 R08
			if (wr_nhhi) near_high_eff_q <= {reg_wdata[wtc_pkg::NEAR_HI_MSB:0], near_high_limit_lo_q}; // R15 R08
		end
	end

	// Wait timer: step prescaler, long-wait sub count, increment down counter
	logic step_end;
	logic sub_end;
	logic [3:0] sub_load;
	assign step_end = step_q == '0;
	assign sub_end = sub_q == 4'h0;
	assign sub_load = long_wait_select ? wtc_pkg::LONG_WAIT_FACTOR - 4'h1 : 4'h0; // R03

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= '0;
			sub_q <= 4'h0;
			inc_q <= 8'h00;
			wait_busy_q <= 1'b0;
			wait_done_q <= 1'b0;
		end else begin
			wait_done_q <= 1'b0;
			if (wait_start && !wait_busy_q) begin
				inc_q <= wait_duration_q; // R02
				sub_q <= sub_load;
				step_q <= STEP_LAST; // R01
				wait_busy_q <= 1'b1;
			end else if (wait_busy_q) begin
				if (!step_end) begin
					step_q <= step_q - SW'(1);
				end else begin
					step_q <= STEP_LAST;
					if (!sub_end) begin
						sub_q <= sub_q - 4'h1; // R03
					end else if (inc_q != 8'h00) begin
						inc_q <= inc_q - 8'h01; // R01 R02
						sub_q <= sub_load;
					end else begin
						wait_busy_q <= 1'b0; // R02
						wait_done_q <= 1'b1;
					end
				end
			end
		end
	end

	// Light range check against the clear channel
	logic light_below;
	logic light_above;
	logic light_out;
	assign light_below = clear_result < light_low_eff_q; // R04 R05
	assign light_above = clear_result > light_high_eff_q; // R06
	assign light_out = light_below || light_above;

	// Proximity range check; short mode uses low-byte registers against bits 9:2
	logic [7:0] near_short;
	logic near_below;
	logic near_above;
	logic near_out;
	assign near_short = near_result[wtc_pkg::NEAR_SHORT_MSB:wtc_pkg::NEAR_SHORT_LSB]; // R13
	assign near_below = pulse_control_off ? near_short < near_low_limit_lo_q // R14
		: near_result < near_low_eff_q; // R10 R11
	assign near_above = pulse_control_off ? near_short > near_high_limit_lo_q // R14
		: near_result > near_high_eff_q; // R18
	assign near_out = near_below || near_above;

	// Light persistence targets: 0..3 direct, then steps of five
	logic [CW-1:0] light_target;
	logic [CW-1:0] near_target;
	// Operands are widened before the multiply so code 15 gives 60 rather than a 4-bit wrap
	assign light_target = light_persistence <= wtc_pkg::LIGHT_PERS_LINEAR_MAX ? CW'(light_persistence)
		: CW'(light_persistence - wtc_pkg::LIGHT_PERS_LINEAR_MAX) * CW'(wtc_pkg::LIGHT_PERS_STEP);
	assign near_target = CW'(near_persistence);

	// Persistence filters run only on finished conversions
	logic light_hit;
	logic near_hit;
	wtc_persist #(
		.CW(CW)
	) u_light_pers (
		.mclk(mclk),
		.rst_n(rst_n),
		.eval(light_done), // R21
		.out_of_range(light_out),
		.target(light_target), // R19
		.hit(light_hit)
	);
	wtc_persist #(
		.CW(CW)
	) u_near_pers (
		.mclk(mclk),
		.rst_n(rst_n),
		.eval(near_done), // R21
		.out_of_range(near_out),
		.target(near_target), // R20
		.hit(near_hit)
	);

	// Sticky flags; a hit in the clearing cycle wins so no event is lost
	logic light_flag_d;
	logic near_flag_d;
	assign light_flag_d = light_hit || (light_flag_q && !light_flag_clear); // R05 R06
	assign near_flag_d = near_hit || (near_flag_q && !near_flag_clear); // R11 R18

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			light_flag_q <= 1'b0;
			near_flag_q <= 1'b0;
			int_n_q <= 1'b1;
		end else begin
			light_flag_q <= light_flag_d;
			near_flag_q <= near_flag_d;
			int_n_q <= !((light_flag_d && light_interrupt_enable) // R07
				|| (near_flag_d && near_interrupt_enable)); // R12
		end
	end

	// Read data is registered; it holds until the next read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			rdata_q <= rd_sel;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_q;
	assign wait_busy = wait_busy_q;
	assign wait_done = wait_done_q;
	assign light_interrupt_flag = light_flag_q;
	assign near_interrupt_flag = near_flag_q;
	assign int_n = int_n_q;
endmodule

// *** wtc_top_sva.sv ***
// Purpose: Port-level checks of wait timing, flag causes and the interrupt pin
// Assumes: STEP_CYCLES equals the value given to the instance
// Notes: Wait length is checked as a whole number of increments, not one exact value
`timescale 1ns/1ns
module wtc_top_sva #(
	parameter int STEP_CYCLES = 4
) (
	// Clock, reset and wait timer
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wait_start,
	input wire logic wait_busy,
	input wire logic wait_done,
	// Results, clears and flags
	input wire logic light_done,
	input wire logic near_done,
	input wire logic light_flag_clear,
	input wire logic light_interrupt_enable,
	input wire logic near_interrupt_enable,
	input wire logic light_interrupt_flag,
	input wire logic near_interrupt_flag,
	input wire logic int_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int busy_q;
	// Busy length of the wait in progress, restarted at each accepted start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			busy_q <= 0;
		else if (wait_start && !wait_busy)
			busy_q <= 0;
		else if (wait_busy)
			busy_q <= busy_q + 1;
	end
	// The done pulse lasts one cycle with busy already low
	sequence done_s;
		wait_done && !wait_busy ##1 !wait_done;
	endsequence
	wait_len_a: assert property ($fell(wait_busy) |-> wait_done && busy_q >= STEP_CYCLES && busy_q % STEP_CYCLES == 0)
		else $error("wait length is not whole increments");
	start_busy_a: assert property (wait_start && !wait_busy |=> wait_busy)
		else $error("accepted start did not raise busy");
	done_pulse_a: assert property (wait_done |-> $past(wait_busy) ##0 done_s)
		else $error("wait done pulse malformed");
	light_cause_a: assert property ($rose(light_interrupt_flag) |-> $past(light_done))
		else $error("light flag rose without a result");
	near_cause_a: assert property ($rose(near_interrupt_flag) |-> $past(near_done))
		else $error("near flag rose without a result");
	light_hold_a: assert property (light_interrupt_flag && !light_flag_clear |=> light_interrupt_flag)
		else $error("light flag dropped without clear");
	light_pin_a: assert property ((light_interrupt_flag && light_interrupt_enable) [*2] |-> !int_n)
		else $error("pin idle with enabled light flag");
	near_pin_a: assert property ((near_interrupt_flag && near_interrupt_enable) [*2] |-> !int_n)
		else $error("pin idle with enabled near flag");
	pin_idle_a: assert property ((!light_interrupt_flag && !near_interrupt_flag) [*2] |-> int_n)
		else $error("pin active with no flag");
endmodule
bind wtc_top wtc_top_sva #(.STEP_CYCLES(STEP_CYCLES)) i_sva (.mclk(mclk), .rst_n(rst_n), .wait_start(wait_start),
	.wait_busy(wait_busy), .wait_done(wait_done), .light_done(light_done), .near_done(near_done),
	.light_flag_clear(light_flag_clear), .light_interrupt_enable(light_interrupt_enable),
	.near_interrupt_enable(near_interrupt_enable), .light_interrupt_flag(light_interrupt_flag),
	.near_interrupt_flag(near_interrupt_flag), .int_n(int_n));

// *** wtc_host.sv ***
// Purpose: Host model issuing register byte writes, reads and threshold pairs
// Assumes: Tasks are entered in the time step of a rising edge
// Notes: Released address and data show inverted last values so stale bytes never match
`timescale 1ns/1ns
module wtc_host (
	// Clock
	input wire logic mclk,
	// Register bus
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One strobe cycle, then release and let an edge pass so calls never overlap
	task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge mclk);
	endtask
	// Low byte then upper byte on the very next cycle; proximity upper bits 7:6 kept zero
	task automatic pair(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= lo;
		@(posedge mclk);
		reg_addr <= a + 8'h01;
		reg_wdata <= (a >= 8'h88) ? (hi & 8'h3f) : hi;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~hi;
		@(posedge mclk);
	endtask
endmodule

// *** wait_timer_threshold_compare_tb.sv ***
// Purpose: Self-checking bench for wait timer, thresholds, persistence and pin
// Assumes: Increment shortened to 4 clocks
// Notes: Flags are judged at the falling edge after the result edge
`timescale 1ns/1ns
module wait_timer_threshold_compare_tb;
	localparam int STEP = 4;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr, reg_rd, wait_busy, wait_done, light_interrupt_flag, near_interrupt_flag, int_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic long_wait_select = 1'b0;
	logic pulse_control_off = 1'b0;
	logic [3:0] light_persistence = 4'h0;
	logic [3:0] near_persistence = 4'h0;
	logic light_interrupt_enable = 1'b0;
	logic near_interrupt_enable = 1'b0;
	logic wait_start = 1'b0;
	logic light_done = 1'b0;
	logic near_done = 1'b0;
	logic [15:0] clear_result = 16'h0;
	logic [13:0] near_result = 14'h0;
	logic light_flag_clear = 1'b0;
	logic near_flag_clear = 1'b0;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	wtc_top #(.STEP_CYCLES(STEP)) i_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .long_wait_select(long_wait_select),
		.pulse_control_off(pulse_control_off), .light_persistence(light_persistence),
		.near_persistence(near_persistence), .light_interrupt_enable(light_interrupt_enable),
		.near_interrupt_enable(near_interrupt_enable), .wait_start(wait_start), .wait_busy(wait_busy),
		.wait_done(wait_done), .light_done(light_done), .clear_result(clear_result), .near_done(near_done),
		.near_result(near_result), .light_flag_clear(light_flag_clear), .near_flag_clear(near_flag_clear),
		.light_interrupt_flag(light_interrupt_flag), .near_interrupt_flag(near_interrupt_flag), .int_n(int_n));
	wtc_host i_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	initial forever #20 mclk = ~mclk;
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		i_host.put(1'b1, a, d);
	endtask
	task automatic pr(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		@(posedge mclk);
		i_host.pair(a, lo, hi);
	endtask
	// Read data holds after the request edge, so it is taken once the host returns
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		i_host.put(1'b0, a, 8'h00);
		chk(exp, reg_rdata);
	endtask
	// One conversion result of either channel; ch high selects proximity
	task automatic res(input logic ch, input logic [15:0] v);
		@(posedge mclk);
		light_done <= !ch;
		near_done <= ch;
		clear_result <= v;
		near_result <= v[13:0];
		@(posedge mclk);
		light_done <= 1'b0;
		near_done <= 1'b0;
		clear_result <= ~v;
		near_result <= ~v[13:0];
		@(negedge mclk);
	endtask
	task automatic clr(input logic ch);
		@(posedge mclk);
		light_flag_clear <= !ch;
		near_flag_clear <= ch;
		@(posedge mclk);
		light_flag_clear <= 1'b0;
		near_flag_clear <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic t_regs;
		for (int a = 8'h83; a < 8'h8c; a++)
			rchk(8'(a), 16'h0);
		rchk(8'h90, 16'h0);
		$display("register reset values done");
	endtask
	task automatic t_wait;
		int n;
		for (int k = 0; k < 2; k++) begin
			w(8'h83, k ? 8'h00 : 8'h01);
			@(posedge mclk);
			long_wait_select <= k[0];
			wait_start <= 1'b1;
			@(posedge mclk);
			wait_start <= 1'b0;
			n = 0;
			@(negedge mclk);
			while (wait_busy === 1'b1 && n < 2000) begin
				n++;
				@(negedge mclk);
			end
			if (k) chk(16'(12 * STEP), 16'(n));
			else chk(16'(2 * STEP), 16'(n));
			chk(16'h1, wait_done);
		end
		$display("wait timer done");
	endtask
	task automatic t_light;
		@(posedge mclk);
		light_persistence <= 4'h2;
		light_interrupt_enable <= 1'b1;
		pr(8'h84, 8'h34, 8'h12);
		pr(8'h86, 8'h00, 8'h80);
		rchk(8'h85, 16'h0012);
		res(1'b0, 16'h1233);
		res(1'b0, 16'h1234);
		res(1'b0, 16'h1233);
		chk(16'h0, light_interrupt_flag);
		res(1'b0, 16'h1233);
		chk(16'h1, light_interrupt_flag);
		chk(16'h0, int_n);
		clr(1'b0);
		chk(16'h1, int_n);
		@(posedge mclk);
		light_persistence <= 4'h1;
		res(1'b0, 16'h8000);
		chk(16'h0, light_interrupt_flag);
		res(1'b0, 16'h8001);
		chk(16'h1, light_interrupt_flag);
		clr(1'b0);
		w(8'h84, 8'h00);
		res(1'b0, 16'h4000);
		res(1'b0, 16'h1233);
		chk(16'h1, light_interrupt_flag);
		clr(1'b0);
		@(posedge mclk);
		light_persistence <= 4'h4;
		res(1'b0, 16'h4000);
		repeat (4) res(1'b0, 16'h1233);
		chk(16'h0, light_interrupt_flag);
		res(1'b0, 16'h1233);
		chk(16'h1, light_interrupt_flag);
		clr(1'b0);
		@(posedge mclk);
		light_interrupt_enable <= 1'b0;
		$display("light thresholds done");
	endtask
	task automatic t_near;
		@(posedge mclk);
		near_persistence <= 4'h1;
		near_interrupt_enable <= 1'b1;
		pr(8'h88, 8'h00, 8'hc1);
		pr(8'h8a, 8'h00, 8'h02);
		rchk(8'h89, 16'h0001);
		res(1'b1, 16'h00ff);
		chk(16'h1, near_interrupt_flag);
		chk(16'h0, int_n);
		clr(1'b1);
		res(1'b1, 16'h0100);
		chk(16'h0, near_interrupt_flag);
		res(1'b1, 16'h0201);
		chk(16'h1, near_interrupt_flag);
		clr(1'b1);
		res(1'b1, 16'h0200);
		chk(16'h0, near_interrupt_flag);
		@(posedge mclk);
		pulse_control_off <= 1'b1;
		w(8'h8a, 8'h40);
		res(1'b1, 16'h00ff);
		chk(16'h0, near_interrupt_flag);
		res(1'b1, 16'h0104);
		chk(16'h1, near_interrupt_flag);
		clr(1'b1);
		$display("proximity thresholds done");
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs;
		t_wait;
		t_light;
		t_near;
		complete_run;
	end
endmodule
